/* File: hdl/emps_media_select.v */
// How it works
// [RULE1] Filters are enabled when the filter strap reads high at configuration.
// [RULE2] Unshielded mode is default; shielded comes from strap or bit D6 of C.
// [RULE3] Unshielded mode drives the positive outputs and floats the negatives.
// [RULE4] Shielded mode drives the negative outputs and floats the positives.
// [RULE5] Auto switching comes from the strap or bit D4 of register C.
// [RULE6] With auto switching and no link pulses the port moves to AUI.
// [RULE7] With auto switching on AUI the port returns to TP on link pulses.
// [RULE8] A port change waits until the current packet has finished; the code holds it only under auto switching.
// [RULE9] A jabbering TP transmitter delays the move to AUI past unjab time.
// [RULE10] The thin-coax enable is raised when auto switching selects AUI.
// [RULE11] Software should enable link integrity along with auto switching.
// [RULE12] Software changes register C only while its enable bit is zero.
// [RULE13] Without auto switching the configured port stays fixed.
`include "emps_consts.vh"
module emps_media_select #(
  parameter UNJAB_CYC = `EMPS_UNJAB_CYC
) (
  input  wire        aclk,
  input  wire        aresetn,
  input  wire        filter_strap_pin,
  input  wire        shield_strap_pin,
  input  wire        autoswitch_strap_pin,
  input  wire        aui_strap_pin,
  input  wire        cfg_done,
  input  wire        link_ok,
  input  wire        pkt_busy,
  input  wire        jabber,
  input  wire        tx_data,
  input  wire        tx_dly,
  output reg         tp_tx_pos,
  output reg         tp_tx_pos_oe,
  output reg         tp_tx_neg,
  output reg         tp_tx_neg_oe,
  output reg         tp_txd_pos,
  output reg         tp_txd_pos_oe,
  output reg         tp_txd_neg,
  output reg         tp_txd_neg_oe,
  output reg         filter_en,
  output reg         aui_sel,
  output reg         thin_en,
  input  wire [3:0]  s_axi_awaddr,
  input  wire        s_axi_awvalid,
  output reg         s_axi_awready,
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output reg         s_axi_wready,
  output reg  [1:0]  s_axi_bresp,
  output reg         s_axi_bvalid,
  input  wire        s_axi_bready,
  input  wire [3:0]  s_axi_araddr,
  input  wire        s_axi_arvalid,
  output reg         s_axi_arready,
  output reg  [31:0] s_axi_rdata,
  output reg  [1:0]  s_axi_rresp,
  output reg         s_axi_rvalid,
  input  wire        s_axi_rready
);
  reg  [7:0] cfgc_q;
  reg        strap_done_q;
  reg        s_filt_q;
  reg        s_stp_q;
  reg        s_auto_q;
  reg        s_aui_q;
  reg        aui_q;
  reg        aui_d;
  reg        aw_q;
  reg        w_q;
  reg  [3:0] awaddr_q;
  reg  [7:0] wbyte_q;
  reg        wlane_q;
  wire       jab_clear;
  wire       stp;
  wire       auto_en;
  wire       want_aui;
  wire       pend;

  emps_unjab_timer #(
    .UNJAB_CYC (UNJAB_CYC)
  ) u_unjab (
    .aclk      (aclk),
    .aresetn   (aresetn),
    .jabber    (jabber),
    .jab_clear (jab_clear)
  );

  // Straps are caught by a clocked process at the end of configuration,
  // never by the reset itself.
  always @(posedge aclk) begin
    if (!aresetn) begin
      strap_done_q <= 1'b0;
      s_filt_q     <= 1'b0;
      s_stp_q      <= 1'b0;
      s_auto_q     <= 1'b0;
      s_aui_q      <= 1'b0;
    end else if (cfg_done && !strap_done_q) begin
      strap_done_q <= 1'b1;
      s_filt_q     <= filter_strap_pin;      // [RULE1]
      s_stp_q      <= shield_strap_pin;      // [RULE2]
      s_auto_q     <= autoswitch_strap_pin;  // [RULE5]
      s_aui_q      <= aui_strap_pin;
    end
  end

  assign stp     = s_stp_q | cfgc_q[`EMPS_CFGC_STP_BIT];    // [RULE2]
  assign auto_en = s_auto_q | cfgc_q[`EMPS_CFGC_AUTO_BIT];  // [RULE5]
  // Auto selection follows link; TP to AUI also waits for unjab.
  assign want_aui = auto_en ? (aui_q ? !link_ok : (!link_ok && jab_clear))
                            : s_aui_q;                      // [RULE6] [RULE9]
  assign pend = (want_aui != aui_q) && pkt_busy;

  always @* begin
    aui_d = aui_q;
    if (!strap_done_q) begin
      aui_d = aui_q;
    end else if (!auto_en) begin
      aui_d = s_aui_q;                                      // [RULE13]
    end else if (!pkt_busy) begin                           // [RULE8]
      if (aui_q && link_ok) begin
        aui_d = 1'b0;                                       // [RULE7]
      end else if (!aui_q && !link_ok && jab_clear) begin
        aui_d = 1'b1;                                       // [RULE6] [RULE9]
      end
    end
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      aui_q         <= 1'b0;
      aui_sel       <= 1'b0;
      thin_en       <= 1'b0;
      filter_en     <= 1'b0;
      tp_tx_pos     <= 1'b0;
      tp_tx_neg     <= 1'b0;
      tp_txd_pos    <= 1'b0;
      tp_txd_neg    <= 1'b0;
      tp_tx_pos_oe  <= 1'b0;
      tp_tx_neg_oe  <= 1'b0;
      tp_txd_pos_oe <= 1'b0;
      tp_txd_neg_oe <= 1'b0;
    end else begin
      aui_q         <= aui_d;
      aui_sel       <= aui_d;
      thin_en       <= auto_en & aui_d;                     // [RULE10]
      filter_en     <= s_filt_q;                            // [RULE1]
      tp_tx_pos     <= tx_data;
      tp_tx_neg     <= tx_data;
      tp_txd_pos    <= tx_dly;
      tp_txd_neg    <= tx_dly;
      tp_tx_pos_oe  <= !stp;                                // [RULE3]
      tp_txd_pos_oe <= !stp;                                // [RULE3]
      tp_tx_neg_oe  <= stp;                                 // [RULE4]
      tp_txd_neg_oe <= stp;                                 // [RULE4]
    end
  end

  // AXI4-Lite write path: address and data are taken in either order.
  always @(posedge aclk) begin
    if (!aresetn) begin
      aw_q          <= 1'b0;
      w_q           <= 1'b0;
      awaddr_q      <= 4'h0;
      wbyte_q       <= 8'h00;
      wlane_q       <= 1'b0;
      s_axi_awready <= 1'b1;
      s_axi_wready  <= 1'b1;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `EMPS_RESP_OKAY;
      cfgc_q        <= `EMPS_CFGC_RESET;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_q          <= 1'b1;
        awaddr_q      <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_q          <= 1'b1;
        wbyte_q      <= s_axi_wdata[7:0];
        wlane_q      <= s_axi_wstrb[0];
        s_axi_wready <= 1'b0;
      end
      if (aw_q && w_q && !s_axi_bvalid) begin
        aw_q         <= 1'b0;
        w_q          <= 1'b0;
        s_axi_bvalid <= 1'b1;
        if (awaddr_q == `EMPS_CFGC_ADDR) begin
          s_axi_bresp <= `EMPS_RESP_OKAY;
          // Writes other than to the enable bit are dropped while it is
          // set, since software is expected to clear it first.
          if (wlane_q) begin
            if (cfgc_q[`EMPS_CFGC_SWEN_BIT]) begin              // [RULE12]
              cfgc_q[`EMPS_CFGC_SWEN_BIT] <= wbyte_q[`EMPS_CFGC_SWEN_BIT];
            end else begin
              cfgc_q <= wbyte_q;
            end
          end
        end else if (awaddr_q == `EMPS_STATUS_ADDR ||
                     awaddr_q == `EMPS_STRAPS_ADDR) begin
          s_axi_bresp <= `EMPS_RESP_OKAY;
        end else begin
          s_axi_bresp <= `EMPS_RESP_SLVERR;
        end
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid  <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready  <= 1'b1;
      end
    end
  end

  // AXI4-Lite read path, one cycle from address to data.
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h00000000;
      s_axi_rresp   <= `EMPS_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      s_axi_rresp   <= `EMPS_RESP_OKAY;
      case (s_axi_araddr)
        `EMPS_CFGC_ADDR: s_axi_rdata <= {24'h000000, cfgc_q};
        `EMPS_STATUS_ADDR: s_axi_rdata <= {25'h0000000, link_ok, pend,
          thin_en, s_filt_q, stp, auto_en, aui_q};
        `EMPS_STRAPS_ADDR: s_axi_rdata <= {27'h0000000, strap_done_q,
          s_aui_q, s_auto_q, s_stp_q, s_filt_q};
        default: begin
          s_axi_rdata <= 32'h00000000;
          s_axi_rresp <= `EMPS_RESP_SLVERR;
        end
      endcase
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid  <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end
  // Link integrity (software's duty with auto switching) is seen as link_ok.
endmodule // emps_media_select

/* File: hdl/emps_unjab_timer.v */
`include "emps_consts.vh"
// Reports jab_clear once jabber has stopped and the unjab time has run.
module emps_unjab_timer #(
  parameter UNJAB_CYC = `EMPS_UNJAB_CYC
) (
  input  wire aclk,
  input  wire aresetn,
  input  wire jabber,
  output reg  jab_clear
);
  reg [15:0] cnt_q;

  always @(posedge aclk) begin
    if (!aresetn) begin
      cnt_q     <= 16'h0000;
      jab_clear <= 1'b1;
    end else if (jabber) begin
      cnt_q     <= UNJAB_CYC[15:0];
      jab_clear <= 1'b0;
    end else if (cnt_q != 16'h0000) begin
      cnt_q     <= cnt_q - 16'h0001;
      jab_clear <= 1'b0;
    end else begin
      jab_clear <= 1'b1;
    end
  end
endmodule // emps_unjab_timer

/* File: inc/emps_consts.vh */
`ifndef EMPS_CONSTS_VH
`define EMPS_CONSTS_VH
// Register byte addresses on the AXI4-Lite slave.
`define EMPS_CFGC_ADDR      4'h0
`define EMPS_STATUS_ADDR    4'h4
`define EMPS_STRAPS_ADDR    4'h8
// Configuration register C fields.
`define EMPS_CFGC_AUTO_BIT  4
`define EMPS_CFGC_STP_BIT   6
`define EMPS_CFGC_SWEN_BIT  7
`define EMPS_CFGC_RESET     8'h00
// Status register fields.
`define EMPS_ST_AUI_BIT     0
`define EMPS_ST_STP_BIT     1
`define EMPS_ST_AUTO_BIT    2
`define EMPS_ST_FILT_BIT    3
`define EMPS_ST_THIN_BIT    4
`define EMPS_ST_PEND_BIT    5
`define EMPS_ST_LINK_BIT    6
// Unjab time in microseconds and its length in 50 ns clock cycles.
`define EMPS_UNJAB_US       500
`define EMPS_CLK_MHZ        20
`define EMPS_UNJAB_CYC      (`EMPS_UNJAB_US * `EMPS_CLK_MHZ)
`define EMPS_RESP_OKAY      2'b00
`define EMPS_RESP_SLVERR    2'b10
`endif

/* File: tb/emps_far_model.sv */
module emps_far_model (
  input wire logic aclk,
  input wire logic cable_on,
  input wire logic tx_pos, tx_pos_oe, tx_neg, tx_neg_oe,
  output logic     link_ok = 1'b0,
  output logic     pos_w,
  output logic     neg_w
);
  timeunit 1ns;
  timeprecision 1ns;
  logic lp_q = 1'b0;
  logic ln_q = 1'b0;
  always @(posedge aclk) begin
    link_ok <= cable_on;
    lp_q <= pos_w;
    ln_q <= neg_w;
  end
  // A floating lead has no pull, so it shows the inverse of its last level.
  assign pos_w = tx_pos_oe ? tx_pos : ~lp_q;
  assign neg_w = tx_neg_oe ? tx_neg : ~ln_q;
endmodule // emps_far_model

/* File: tb/emps_media_select_asserts.sv */
module emps_media_select_asserts #(parameter int UNJAB_CYC = 8) (
  input wire logic aclk, aresetn, cfg_done, filter_strap_pin,
  input wire logic link_ok, pkt_busy, jabber, filter_en, aui_sel, thin_en,
  input wire logic tp_tx_pos_oe, tp_txd_pos_oe, tp_tx_neg_oe, tp_txd_neg_oe
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // Cycles since jabber was last seen; a switch to AUI must not beat it.
  int jcnt_q = 0;
  always @(posedge aclk) jcnt_q <= jabber ? 0 : jcnt_q + 1;
  chk_oe_pattern: assert property ($past(aresetn) |->
    tp_tx_pos_oe == tp_txd_pos_oe && tp_tx_neg_oe == tp_txd_neg_oe &&
    tp_tx_pos_oe != tp_tx_neg_oe) else $error("drive enables wrong");
  chk_thin_aui: assert property (thin_en |-> aui_sel || $past(aui_sel))
    else $error("thin enable without AUI");
  chk_busy_hold: assert property ($changed(aui_sel) |-> !$past(pkt_busy))
    else $error("port moved during packet");
  chk_to_aui: assert property ($rose(aui_sel) |-> !$past(link_ok))
    else $error("AUI chosen with link");
  chk_unjab_wait: assert property ($rose(aui_sel) |->
    $past(jcnt_q) >= UNJAB_CYC) else $error("AUI chosen before unjab");
  chk_to_tp: assert property ($fell(aui_sel) |-> $past(link_ok))
    else $error("TP chosen without link");
  chk_tp_return: assert property (aui_sel && link_ok && !pkt_busy |=>
    !aui_sel) else $error("no return to TP");
  chk_filter_latch: assert property ($changed(filter_en) |->
    $past(cfg_done) && filter_en == $past(filter_strap_pin))
    else $error("filter enable wrong");
  cov_aui: cover property ($rose(aui_sel));
  cov_tp: cover property ($fell(aui_sel));
  cov_stp: cover property ($rose(tp_tx_neg_oe));
endmodule // emps_media_select_asserts

/* File: tb/emps_media_select_tb.sv */
module emps_media_select_tb;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int UJ = 8;
  logic aclk, aresetn, filter_strap_pin, shield_strap_pin, autoswitch_strap_pin;
  logic cfg_done, link_ok, pkt_busy, jabber, tx_data, tx_dly, cable_on;
  logic tp_tx_pos, tp_tx_pos_oe, tp_tx_neg, tp_tx_neg_oe, tp_txd_pos, pos_w;
  logic tp_txd_pos_oe, tp_txd_neg, tp_txd_neg_oe, filter_en, aui_sel, thin_en;
  logic neg_w, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic s_axi_rvalid, s_axi_rready;
  logic [3:0] s_axi_awaddr, s_axi_araddr, s_axi_wstrb;
  logic [31:0] s_axi_wdata, s_axi_rdata, r;
  logic [1:0] s_axi_bresp, s_axi_rresp, rs;
  int err_total, checks, cyc, n, seed;
  emps_media_select #(.UNJAB_CYC(UJ)) DUT (.aclk, .aresetn, .filter_strap_pin,
    .shield_strap_pin, .autoswitch_strap_pin, .aui_strap_pin(1'b0), .cfg_done,
    .link_ok, .pkt_busy, .jabber, .tx_data, .tx_dly, .tp_tx_pos, .tp_tx_pos_oe,
    .tp_tx_neg, .tp_tx_neg_oe, .tp_txd_pos, .tp_txd_pos_oe, .tp_txd_neg,
    .tp_txd_neg_oe, .filter_en, .aui_sel, .thin_en, .s_axi_awaddr,
    .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
    .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready);
  emps_far_model far (.aclk, .cable_on, .tx_pos(tp_tx_pos), .link_ok, .pos_w,
    .tx_pos_oe(tp_tx_pos_oe), .tx_neg(tp_tx_neg), .tx_neg_oe(tp_tx_neg_oe),
    .neg_w);
  initial begin
    aclk = 0;
    forever #25 aclk = ~aclk;
  end
  task automatic summarize();
    $display("checks=%0d err_total=%0d", checks, err_total);
    if (err_total == 0 && checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  always @(posedge aclk) begin
    cyc++;
    if (cyc == 3000) begin
      err_total++;
      summarize();
    end
  end
  task automatic ck(input logic [31:0] g, e);
    checks++;
    if (g !== e) begin
      err_total++;
      $display("CHECK FAILED t=%0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1;
    s_axi_wvalid <= 1;
    s_axi_bready <= 1;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 0;
      if (s_axi_wready) s_axi_wvalid <= 0;
    end while (!s_axi_bvalid);
    rs = s_axi_bresp;
    s_axi_bready <= 0;
  endtask
  task automatic rd(input logic [3:0] a);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1;
    s_axi_rready <= 1;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 0;
    end while (!s_axi_rvalid);
    r = s_axi_rdata;
    rs = s_axi_rresp;
    s_axi_rready <= 0;
  endtask
  task automatic wp(input logic v);
    n = 0;
    while (aui_sel !== v && n < 200) begin
      @(posedge aclk);
      n++;
    end
  endtask
  initial begin
    {aresetn, shield_strap_pin, autoswitch_strap_pin, cfg_done, pkt_busy} = 0;
    {jabber, tx_data, tx_dly, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 0;
    {s_axi_arvalid, s_axi_rready, s_axi_awaddr, s_axi_araddr} = 0;
    s_axi_wdata = 0;
    s_axi_wstrb = 4'hf;
    filter_strap_pin = 1;
    cable_on = 1;
    seed = 84;
    repeat (12) @(posedge aclk);
    aresetn <= 1;
    cfg_done <= 1;
    repeat (3) @(posedge aclk);
    #1 ck(filter_en, 1);
    ck({tp_tx_pos_oe, tp_txd_pos_oe, tp_tx_neg_oe, tp_txd_neg_oe}, 4'hc);
    repeat (8) begin
      @(posedge aclk);
      tx_data <= $random(seed);
      tx_dly <= $random(seed);
      @(posedge aclk);
      #1 ck({pos_w, tp_txd_pos}, {tx_data, tx_dly});
    end
    @(posedge aclk) cable_on <= 0;
    repeat (30) @(posedge aclk);
    ck(aui_sel, 0);
    rd(4'h0);
    ck(r, 0);
    rd(4'hc);
    ck(rs, 2'b10);
    rd(4'h8);
    ck(r[4:0], 5'h11);
    wr(4'hc, 32'h0);
    ck(rs, 2'b10);
    wr(4'h0, 32'h40);
    ck(rs, 2'b00);
    repeat (3) @(posedge aclk);
    #1 ck({tp_tx_pos_oe, tp_txd_pos_oe, tp_tx_neg_oe, tp_txd_neg_oe}, 4'h3);
    repeat (4) begin
      @(posedge aclk);
      tx_data <= $random(seed);
      tx_dly <= $random(seed);
      @(posedge aclk);
      #1 ck({neg_w, tp_txd_neg}, {tx_data, tx_dly});
    end
    // Link is up before auto switching is enabled, as software should do.
    @(posedge aclk) cable_on <= 1;
    wr(4'h0, 32'hc0);
    wr(4'h0, 32'h10);
    rd(4'h0);
    ck(r, 32'h40);
    wr(4'h0, 32'h50);
    rd(4'h4);
    ck(r[2:0], 3'h6);
    @(posedge aclk);
    pkt_busy <= 1;
    cable_on <= 0;
    repeat (30) @(posedge aclk);
    ck(aui_sel, 0);
    pkt_busy <= 0;
    wp(1);
    ck(aui_sel, 1);
    repeat (2) @(posedge aclk);
    ck(thin_en, 1);
    pkt_busy <= 1;
    cable_on <= 1;
    repeat (20) @(posedge aclk);
    ck(aui_sel, 1);
    pkt_busy <= 0;
    wp(0);
    ck(aui_sel, 0);
    jabber <= 1;
    cable_on <= 0;
    repeat (5) @(posedge aclk);
    jabber <= 0;
    wp(1);
    ck({aui_sel, n >= UJ}, 2'b11);
    summarize();
  end
endmodule // emps_media_select_tb
bind emps_media_select emps_media_select_asserts #(.UNJAB_CYC(UNJAB_CYC)) u_chk
  (.aclk, .aresetn, .cfg_done, .filter_strap_pin, .link_ok, .pkt_busy, .jabber,
  .filter_en, .aui_sel, .thin_en, .tp_tx_pos_oe, .tp_txd_pos_oe, .tp_tx_neg_oe,
  .tp_txd_neg_oe);
